// file: hw/hpp_consts.vh
`ifndef HPP_CONSTS_VH
`define HPP_CONSTS_VH
// Register offsets
`define HPP_ADDR_CFG_ONE 8'h06
`define HPP_ADDR_CFG_TWO 8'h07
// Byte one fields
`define HPP_B1_SELF_PWR 7
`define HPP_B1_EOP_SUP 3
`define HPP_B1_OCS_HI 2
`define HPP_B1_OCS_LO 1
`define HPP_B1_PORT_POWER_SWITCH_MODE 0
`define HPP_B1_MASK 8'h8f
`define HPP_B1_RESET 8'h00
// Byte two fields
`define HPP_B2_DYNAMIC 7
`define HPP_B2_OCT_HI 5
`define HPP_B2_OCT_LO 4
`define HPP_B2_COMPOUND 3
`define HPP_B2_MASK 8'hb8
`define HPP_B2_RESET 8'h00
// Sense modes
`define HPP_OCS_GANGED 2'h0
`define HPP_OCS_INDIV 2'h1
// Over-current filter delays in 50 ns cycles: 0.1 ms, 4 ms, 8 ms, 16 ms
// Sized to the 20-bit filter counters so no bits are dropped on assignment
`define HPP_OCT0_CYC 20'h007d0
`define HPP_OCT1_CYC 20'h13880
`define HPP_OCT2_CYC 20'h27100
`define HPP_OCT3_CYC 20'h4e200
// Detach hold time after a power source change, in cycles
`define HPP_DETACH_CYC 16'h0010
`endif

// file: hw/hpp_hub_power_port_config.v
`timescale 1ns/1ps
`include "hpp_consts.vh"
module hpp_hub_power_port_config (
	input wire clk,
	input wire rst,
	input wire cfgWrite,
	input wire [7:0] cfgAddr,
	input wire [7:0] cfgWrData,
	output reg [7:0] cfgRdData,
	input wire strapConfig,
	input wire [1:0] strapNonRemovable,
	input wire fullSpeedMode,
	input wire eof1Point,
	input wire downstreamTraffic,
	input wire suspendState,
	input wire [1:0] overcurrentIn,
	input wire localSupplyPinIn,
	output reg localSupplyPinOut,
	output reg localSupplyPinOe,
	output reg eopPulse,
	output reg hubStatusLocalPower,
	output reg selfPowered,
	output reg compoundReport,
	output reg upstreamAttach,
	output reg [1:0] portPowerOn,
	output reg [1:0] overcurrentFlag,
	output reg overcurrentSensing,
	output reg portPowerIndividual
);
	////////////////////////////////////////////////////////////////
	reg [7:0] cfgOne_reg;
	reg [7:0] cfgTwo_reg;
	reg [2:0] supplySync_reg;
	reg supplyLevel_reg;
	reg [1:0] ocSync1_reg;
	reg [1:0] ocSync2_reg;
	reg [1:0] ocSync3_reg;
	reg [19:0] ocCount0_reg;
	reg [19:0] ocCount1_reg;
	reg [15:0] detachCount_reg;
	reg [15:0] detachCount_next;
	reg [19:0] ocLimit;
	wire autoSwitch;
	wire [1:0] senseSel;
	wire selfNow;
	wire supplyAgree;
	wire [1:0] ocLevel;

	assign autoSwitch = cfgTwo_reg[`HPP_B2_DYNAMIC];
	assign senseSel = {cfgOne_reg[`HPP_B1_OCS_HI], cfgOne_reg[`HPP_B1_OCS_LO]};
	// Second and third stage agreeing filters one-cycle glitches on the pin
	assign supplyAgree = supplySync_reg[1] == supplySync_reg[2];
	assign ocLevel = ocSync2_reg & ocSync3_reg;
	assign selfNow = autoSwitch ? supplyLevel_reg : cfgOne_reg[`HPP_B1_SELF_PWR];

	// Filter delay per field value
	function [19:0] ocDelay;
		input [1:0] sel;
		begin
			case (sel)
				2'h0: ocDelay = `HPP_OCT0_CYC;
				2'h1: ocDelay = `HPP_OCT1_CYC;
				2'h2: ocDelay = `HPP_OCT2_CYC;
				default: ocDelay = `HPP_OCT3_CYC;
			endcase
		end
	endfunction

	// Filter counter step: counts while asserted, clears when released
	function [19:0] ocStep;
		input level;
		input [19:0] count;
		input [19:0] limit;
		begin
			if (!level) begin
				ocStep = 20'h00000;
			end else if (count < limit) begin
				ocStep = count + 20'h00001;
			end else begin
				ocStep = count;
			end
		end
	endfunction

	always @* begin
		ocLimit = ocDelay({cfgTwo_reg[`HPP_B2_OCT_HI], cfgTwo_reg[`HPP_B2_OCT_LO]});
	end

	////////////////////////////////////////////////////////////////
	// Register file
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			cfgOne_reg <= `HPP_B1_RESET;
			cfgTwo_reg <= `HPP_B2_RESET;
		end else if (cfgWrite) begin
			if (cfgAddr == `HPP_ADDR_CFG_ONE) begin
				cfgOne_reg <= cfgWrData & `HPP_B1_MASK;
			end else if (cfgAddr == `HPP_ADDR_CFG_TWO) begin
				cfgTwo_reg <= cfgWrData & `HPP_B2_MASK;
			end
		end
	end

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			cfgRdData <= 8'h00;
		end else if (cfgAddr == `HPP_ADDR_CFG_ONE) begin
			cfgRdData <= cfgOne_reg;
		end else if (cfgAddr == `HPP_ADDR_CFG_TWO) begin
			cfgRdData <= cfgTwo_reg;
		end else begin
			cfgRdData <= 8'h00;
		end
	end

	////////////////////////////////////////////////////////////////
	// Pin synchronisers
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			supplySync_reg <= 3'h0;
			supplyLevel_reg <= 1'b0;
			ocSync1_reg <= 2'h0;
			ocSync2_reg <= 2'h0;
			ocSync3_reg <= 2'h0;
		end else begin
			// Pin is an output while auto switching is off, so its input is masked
			supplySync_reg <= {supplySync_reg[1:0], localSupplyPinIn & autoSwitch};
			if (supplyAgree) begin
				supplyLevel_reg <= supplySync_reg[2];
			end
			ocSync1_reg <= overcurrentIn;
			ocSync2_reg <= ocSync1_reg;
			ocSync3_reg <= ocSync2_reg;
		end
	end

	////////////////////////////////////////////////////////////////
	// Over-current filtering and sensing mode
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			ocCount0_reg <= 20'h00000;
			ocCount1_reg <= 20'h00000;
			overcurrentFlag <= 2'h0;
			overcurrentSensing <= 1'b0;
		end else begin
			ocCount0_reg <= ocStep(ocLevel[0], ocCount0_reg, ocLimit);
			ocCount1_reg <= ocStep(ocLevel[1], ocCount1_reg, ocLimit);
			overcurrentSensing <= ~senseSel[1];
			if (senseSel[1]) begin
				overcurrentFlag <= 2'h0;
			end else if (senseSel == `HPP_OCS_INDIV) begin
				overcurrentFlag <= {ocCount1_reg >= ocLimit, ocCount0_reg >= ocLimit};
			end else begin
				// Ganged: any port trip is reported on both
				overcurrentFlag <= {2{(ocCount0_reg >= ocLimit) | (ocCount1_reg >= ocLimit)}};
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// Power source change: detach, depower, then reattach
	always @* begin
		detachCount_next = detachCount_reg;
		if (autoSwitch && supplyAgree && supplySync_reg[2] != supplyLevel_reg) begin
			detachCount_next = `HPP_DETACH_CYC;
		end else if (detachCount_reg != 16'h0000) begin
			detachCount_next = detachCount_reg - 16'h0001;
		end
	end

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			detachCount_reg <= 16'h0000;
			upstreamAttach <= 1'b0;
			portPowerOn <= 2'h0;
			selfPowered <= 1'b0;
			hubStatusLocalPower <= 1'b0;
			portPowerIndividual <= 1'b0;
		end else begin
			detachCount_reg <= detachCount_next;
			upstreamAttach <= detachCount_next == 16'h0000;
			// Ports stay off while detached; both ports are powered whenever attached
			portPowerOn <= (detachCount_next == 16'h0000) ? 2'h3 : 2'h0;
			selfPowered <= selfNow;
			if (autoSwitch) begin
				hubStatusLocalPower <= supplyLevel_reg;
			end else begin
				hubStatusLocalPower <= ~cfgOne_reg[`HPP_B1_SELF_PWR];
			end
			portPowerIndividual <= cfgOne_reg[`HPP_B1_PORT_POWER_SWITCH_MODE];
		end
	end

	////////////////////////////////////////////////////////////////
	// Shared pin, EOP and compound reporting
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			localSupplyPinOut <= 1'b0;
			localSupplyPinOe <= 1'b0;
			eopPulse <= 1'b0;
			compoundReport <= 1'b0;
		end else begin
			localSupplyPinOe <= ~autoSwitch;
			localSupplyPinOut <= ~autoSwitch & suspendState;
			eopPulse <= eof1Point & ~downstreamTraffic & fullSpeedMode
				& ~cfgOne_reg[`HPP_B1_EOP_SUP];
			if (strapConfig) begin
				compoundReport <= |strapNonRemovable;
			end else begin
				compoundReport <= cfgTwo_reg[`HPP_B2_COMPOUND];
			end
		end
	end
endmodule

// file: verif/hpp_checker_sva.sv
`timescale 1ns/1ps
module hpp_checker (
	input wire clk,
	input wire rst,
	input wire [7:0] cfgAddr,
	input wire [7:0] cfgRdData,
	input wire fullSpeedMode,
	input wire eof1Point,
	input wire downstreamTraffic,
	input wire eopPulse,
	input wire upstreamAttach,
	input wire [1:0] portPowerOn,
	input wire [1:0] overcurrentFlag,
	input wire overcurrentSensing
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	sequence detachHeld;
		!upstreamAttach [*8];
	endsequence
	a_eop_cause: assert property (eopPulse |-> $past(eof1Point) && !$past(downstreamTraffic))
		else $error("EOP pulse without a quiet EOF1");
	a_hs_no_eop: assert property (!$past(fullSpeedMode) |-> !eopPulse)
		else $error("EOP pulse outside full speed");
	a_eop_single: assert property (eopPulse |=> !eopPulse)
		else $error("EOP pulse longer than one cycle");
	a_two_reserved: assert property ($past(cfgAddr) == 8'h07 |-> (cfgRdData & 8'h47) == 8'h00)
		else $error("reserved bits of byte two read nonzero");
	a_unmapped_zero: assert property ($past(cfgAddr) != 8'h06 && $past(cfgAddr) != 8'h07
		|-> cfgRdData == 8'h00)
		else $error("unmapped read nonzero");
	a_detach_power: assert property (!upstreamAttach |-> portPowerOn == 2'h0)
		else $error("port power on while detached");
	a_detach_bound: assert property ($fell(upstreamAttach) |-> detachHeld ##[1:40] upstreamAttach)
		else $error("detach too short or never ends");
	a_sense_off: assert property (!overcurrentSensing [*3] |-> overcurrentFlag == 2'h0)
		else $error("over-current flag with sensing off");
endmodule
bind hpp_hub_power_port_config hpp_checker chk (
	.clk(clk),
	.rst(rst),
	.cfgAddr(cfgAddr),
	.cfgRdData(cfgRdData),
	.fullSpeedMode(fullSpeedMode),
	.eof1Point(eof1Point),
	.downstreamTraffic(downstreamTraffic),
	.eopPulse(eopPulse),
	.upstreamAttach(upstreamAttach),
	.portPowerOn(portPowerOn),
	.overcurrentFlag(overcurrentFlag),
	.overcurrentSensing(overcurrentSensing)
);

// file: verif/hpp_host_model.sv
`timescale 1ns/1ps
module hpp_host_model #(
	parameter int FRAME = 40
) (
	input wire logic clk,
	input wire logic rst,
	output logic eof1Point
);
	logic [7:0] frameCnt_reg;
	// Frames shortened so the run stays brief; the hub does not care about their length
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			frameCnt_reg <= 8'h00;
			eof1Point <= 1'h0;
		end else begin
			frameCnt_reg <= (frameCnt_reg == FRAME - 1) ? 8'h00 : frameCnt_reg + 8'h01;
			eof1Point <= (frameCnt_reg == FRAME - 1);
		end
	end
endmodule

// file: verif/hpp_tb.sv
`timescale 1ns/1ps
module testbench;
	logic clk, rst = 1'h1, cfgWrite = 1'h0, strapConfig = 1'h0, fullSpeedMode = 1'h1;
	logic downstreamTraffic = 1'h0, suspendState = 1'h0, supplyDrv = 1'h0;
	logic [7:0] cfgAddr = 8'h00, cfgWrData = 8'h00;
	logic [1:0] strapNonRemovable = 2'h0, overcurrentIn = 2'h0;
	wire [7:0] cfgRdData;
	wire [1:0] portPowerOn, overcurrentFlag;
	wire eof1Point, localSupplyPinIn, localSupplyPinOut, localSupplyPinOe, eopPulse;
	wire hubStatusLocalPower, selfPowered, compoundReport, upstreamAttach;
	wire overcurrentSensing, portPowerIndividual;
	int num_errors = 0;
	int comparisons = 0;
	int cycles = 0;
	// Shared pin: the hub drives it as an indicator, else the supply sensor does
	assign localSupplyPinIn = localSupplyPinOe ? localSupplyPinOut : supplyDrv;
	hpp_hub_power_port_config uut (
		.clk(clk),
		.rst(rst),
		.cfgWrite(cfgWrite),
		.cfgAddr(cfgAddr),
		.cfgWrData(cfgWrData),
		.cfgRdData(cfgRdData),
		.strapConfig(strapConfig),
		.strapNonRemovable(strapNonRemovable),
		.fullSpeedMode(fullSpeedMode),
		.eof1Point(eof1Point),
		.downstreamTraffic(downstreamTraffic),
		.suspendState(suspendState),
		.overcurrentIn(overcurrentIn),
		.localSupplyPinIn(localSupplyPinIn),
		.localSupplyPinOut(localSupplyPinOut),
		.localSupplyPinOe(localSupplyPinOe),
		.eopPulse(eopPulse),
		.hubStatusLocalPower(hubStatusLocalPower),
		.selfPowered(selfPowered),
		.compoundReport(compoundReport),
		.upstreamAttach(upstreamAttach),
		.portPowerOn(portPowerOn),
		.overcurrentFlag(overcurrentFlag),
		.overcurrentSensing(overcurrentSensing),
		.portPowerIndividual(portPowerIndividual)
	);
	hpp_host_model host (.clk, .rst, .eof1Point);
	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		cfgAddr = a;
		cfgWrData = d;
		cfgWrite = 1'h1;
		tick(1);
		cfgWrite = 1'h0;
		tick(2);
	endtask
	task automatic test_done;
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task automatic testRegs;
		cfgAddr = 8'h07;
		tick(1);
		check(cfgRdData, 8'h00);
		wr(8'h07, 8'hff);
		check(cfgRdData, 8'hb8);
		wr(8'h06, 8'h7f);
		check(cfgRdData, 8'h0f);
		check(portPowerIndividual, 8'h01);
		cfgAddr = 8'h10;
		tick(1);
		check(cfgRdData, 8'h00);
		wr(8'h07, 8'h00);
		wr(8'h06, 8'h00);
		check(portPowerIndividual, 8'h00);
	endtask
	task automatic testEop;
		for (int i = 0; i < 4; i++) begin
			fullSpeedMode = (i != 1);
			downstreamTraffic = (i == 2);
			wr(8'h06, (i == 3) ? 8'h08 : 8'h00);
			do tick(1); while (eof1Point !== 1'h1);
			tick(1);
			check(eopPulse, i == 0);
		end
		fullSpeedMode = 1'h1;
	endtask
	task automatic testOvercurrent;
		wr(8'h06, 8'h02);
		overcurrentIn = 2'h1;
		tick(1990);
		check(overcurrentFlag, 8'h00);
		tick(20);
		check(overcurrentFlag, 8'h01);
		wr(8'h06, 8'h00);
		overcurrentIn = 2'h2;
		tick(2010);
		check(overcurrentFlag, 8'h03);
		wr(8'h06, 8'h04);
		check(overcurrentSensing, 8'h00);
		overcurrentIn = 2'h0;
	endtask
	task automatic testPower;
		suspendState = 1'h1;
		tick(2);
		check(localSupplyPinOut, 8'h01);
		suspendState = 1'h0;
		check(localSupplyPinOe, 8'h01);
		check(hubStatusLocalPower, 8'h01);
		wr(8'h06, 8'h80);
		check({selfPowered, hubStatusLocalPower}, 8'h02);
		wr(8'h07, 8'h80);
		tick(30);
		check({localSupplyPinOe, selfPowered}, 8'h00);
		supplyDrv = 1'h1;
		tick(8);
		check({upstreamAttach, portPowerOn}, 8'h00);
		tick(30);
		check({upstreamAttach, selfPowered, hubStatusLocalPower}, 8'h07);
		supplyDrv = 1'h0;
		tick(40);
		check({selfPowered, hubStatusLocalPower}, 8'h00);
	endtask
	task automatic testCompound;
		wr(8'h07, 8'h08);
		check(compoundReport, 8'h01);
		wr(8'h07, 8'h00);
		check(compoundReport, 8'h00);
		strapConfig = 1'h1;
		strapNonRemovable = 2'h2;
		tick(3);
		check(compoundReport, 8'h01);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'h0;
		forever #25 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			test_done();
		end
	end
	initial begin
		tick(3);
		rst = 1'h0;
		testRegs();
		testEop();
		testOvercurrent();
		testPower();
		testCompound();
		test_done();
	end
endmodule
